// file: rtl/rrd_pkg.sv
// package: widths, reset values, operation codes and shared decode for the rotate/return datapath
package rrd_pkg;

  localparam int WORD_W = 32;
  localparam int EXP_W = 8;
  localparam int EXT_W = EXP_W + WORD_W;
  localparam int SEL_W = 3;
  localparam int NUM_SEL = 8;
  localparam int TRAP_W = 5;
  localparam logic [TRAP_W-1:0] TRAP_MAX = 5'h1B;
  localparam logic [WORD_W:0] ROUND_HALF = 33'h0_0000_0080;
  localparam logic [WORD_W-1:0] ROUND_KEEP_MASK = 32'hFFFF_FF00;
  localparam logic [EXP_W-1:0] EXP_ONE = 8'h01;
  localparam logic [WORD_W-1:0] PC_RESET = 32'h0000_0000;
  localparam logic [WORD_W-1:0] PC_STEP = 32'h0000_0001;
  localparam logic [EXT_W-1:0] EXT_RESET = 40'h00_0000_0000;

  typedef enum logic [2:0] {
    OP_RETS,
    OP_RND,
    OP_ROL,
    OP_ROTATE_LEFT_VIA_CARRY,
    OP_ROR,
    OP_ROTATE_RIGHT_VIA_CARRY,
    OP_TRAP
  } rrd_op_t;

  typedef enum {
    ST_IDLE,
    ST_RET_READ
  } rrd_state_t;

  // one-hot decode of a three-bit register select field
  function automatic logic [NUM_SEL-1:0] rrd_onehot(input logic [SEL_W-1:0] sel);
    rrd_onehot = '0;
    rrd_onehot[sel] = 1'b1;
  endfunction : rrd_onehot

  // round a signed mantissa to single-precision length; exponent overflow is not saturated
  function automatic logic [EXT_W-1:0] round_single(input logic [EXT_W-1:0] src);
    logic [WORD_W:0] sum;
    logic [EXP_W-1:0] ex;
    logic [WORD_W-1:0] man;
    sum = {src[WORD_W-1], src[WORD_W-1:0]} + ROUND_HALF;
    ex = src[EXT_W-1:WORD_W];
    man = sum[WORD_W-1:0];
    // sign change means the mantissa overflowed: renormalise by one place
    if (sum[WORD_W] != sum[WORD_W-1]) begin
      man = sum[WORD_W:1];
      ex = ex + EXP_ONE;
    end
    round_single = {ex, man & ROUND_KEEP_MASK};
  endfunction : round_single

endpackage : rrd_pkg

// file: rtl/rrd_stack_mem.sv
// stack memory: one write port, one read port with registered read data
`timescale 1ns/1ps
`default_nettype none
module rrd_stack_mem #(
  parameter int WIDTH = 32,
  parameter int AW = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // read port, data one cycle after the address
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  // the array size grows with two to the address width, so keep it bounded
  if (WIDTH < 1 || AW < 1 || AW > 16) begin : g_bad_param
    $error("rrd_stack_mem: WIDTH must be positive and AW must lie in 1..16");
  end

  logic [WIDTH-1:0] mem [0:(1<<AW)-1];

  // storage array carries no reset, so it maps onto plain ram
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : rrd_stack_mem
`default_nettype wire

// file: rtl/rrd_datapath.sv
// datapath slice: conditional return, float round, one-bit rotates, operand field checks
//
// Contract
// - conditional return loads counter from stack top
// - plain left rotate wraps top bit around
// - left rotate through carry flag
// - plain right rotate wraps bottom bit around
// - right rotate through carry flag
// - aux field selects one of eight
// - extended register field selects one of eight
// - trap numbers accepted only zero to 27
`timescale 1ns/1ps
`default_nettype none
module rrd_datapath
  import rrd_pkg::*;
#(
  parameter int STACK_AW = 8
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // operation request from the decoder
  input wire logic OP_VALID,
  input wire rrd_op_t OP_CODE,
  input wire logic COND_GIVEN,
  input wire logic COND_TRUE,
  input wire logic [SEL_W-1:0] DST_SEL,
  input wire logic [EXT_W-1:0] SRC_OPERAND,
  input wire logic [TRAP_W-1:0] TRAP_NUM,
  // register load and stack push from other instructions
  input wire logic LOAD_VALID,
  input wire logic [SEL_W-1:0] LOAD_SEL,
  input wire logic [EXT_W-1:0] LOAD_DATA,
  input wire logic PUSH_VALID,
  input wire logic [WORD_W-1:0] PUSH_DATA,
  // auxiliary register field
  input wire logic AUX_STROBE,
  input wire logic [SEL_W-1:0] AUX_FIELD,
  // observation read of the extended registers
  input wire logic [SEL_W-1:0] RD_SEL,
  output logic [EXT_W-1:0] RD_DATA,
  // state and results
  output logic BUSY,
  output logic DONE,
  output logic [WORD_W-1:0] PC_OUT,
  output logic [STACK_AW-1:0] SP_OUT,
  output logic CARRY_OUT,
  output logic [NUM_SEL-1:0] AUX_ENABLE,
  output logic TRAP_TAKEN,
  output logic TRAP_REJECT,
  output logic [TRAP_W-1:0] TRAP_VECTOR
);

  if (STACK_AW < 1 || STACK_AW > 16) begin : g_bad_stack_aw
    $error("rrd_datapath: STACK_AW must lie in 1..16");
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  logic rst_meta_r, rst_n;
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  rrd_state_t state_r;
  logic [EXT_W-1:0] ext_r [NUM_SEL];
  logic [WORD_W-1:0] pc_r, mem_rdata, dst_low;
  logic [STACK_AW-1:0] sp_r;
  logic carry_r, done_r, busy_r, trap_taken_r, trap_reject_r;
  logic [TRAP_W-1:0] trap_vec_r;
  logic [NUM_SEL-1:0] aux_en_r, wr_en;
  logic [EXT_W-1:0] rd_data_r, wr_data, round_res;
  logic op_take, ret_taken, op_writes, load_take, push_take, carry_nxt, carry_wr;

  ////////////////////////////////////////////////////////////////////////////
  // request decode; operation requests and pushes are only taken while idle, loads in any state
  assign op_take = OP_VALID && (state_r == ST_IDLE);
  assign ret_taken = op_take && (OP_CODE == OP_RETS) && (COND_TRUE || !COND_GIVEN);
  assign dst_low = ext_r[DST_SEL][WORD_W-1:0];
  assign round_res = round_single(SRC_OPERAND);
  assign op_writes = op_take && (OP_CODE inside {OP_RND, OP_ROL, OP_ROTATE_LEFT_VIA_CARRY, OP_ROR, OP_ROTATE_RIGHT_VIA_CARRY});
  assign load_take = LOAD_VALID && !op_writes;
  // push shares the pointer with the return, so it waits for an idle, request-free cycle
  assign push_take = PUSH_VALID && (state_r == ST_IDLE) && !OP_VALID;

  // result and carry selection for the register write
  always_comb begin
    wr_data = ext_r[DST_SEL];
    carry_nxt = carry_r;
    carry_wr = 1'b0;
    case (OP_CODE)
      OP_RND: wr_data = round_res;
      OP_ROL: wr_data[WORD_W-1:0] = {dst_low[WORD_W-2:0], dst_low[WORD_W-1]};
      OP_ROR: wr_data[WORD_W-1:0] = {dst_low[0], dst_low[WORD_W-1:1]};
      OP_ROTATE_LEFT_VIA_CARRY: begin
        wr_data[WORD_W-1:0] = {dst_low[WORD_W-2:0], carry_r};
        carry_nxt = dst_low[WORD_W-1];
        carry_wr = 1'b1;
      end
      OP_ROTATE_RIGHT_VIA_CARRY: begin
        wr_data[WORD_W-1:0] = {carry_r, dst_low[WORD_W-1:1]};
        carry_nxt = dst_low[0];
        carry_wr = 1'b1;
      end
      default: wr_data = ext_r[DST_SEL];
    endcase
    if (op_writes) begin
      wr_en = rrd_onehot(DST_SEL);
    end else if (load_take) begin
      wr_en = rrd_onehot(LOAD_SEL);
      wr_data = LOAD_DATA;
    end else begin
      wr_en = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // extended-precision register bank
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_SEL; i++) begin
        ext_r[i] <= EXT_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_SEL; i++) begin
        if (wr_en[i]) begin
          ext_r[i] <= wr_data;
        end
      end
    end
  end

  // carry flag
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      carry_r <= 1'b0;
    end else if (op_take && carry_wr) begin
      carry_r <= carry_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing, program counter and stack pointer
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      pc_r <= PC_RESET;
      sp_r <= '0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (ret_taken) begin
            state_r <= ST_RET_READ;
          end else if (op_take) begin
            pc_r <= pc_r + PC_STEP;
            done_r <= 1'b1;
          end else if (push_take) begin
            sp_r <= sp_r + 1'b1;
          end
        end
        ST_RET_READ: begin
          pc_r <= mem_rdata;
          sp_r <= sp_r - 1'b1;
          done_r <= 1'b1;
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // stack top is read every cycle at the pointer; data is ready one cycle after a taken return
  rrd_stack_mem #(
    .WIDTH(WORD_W),
    .AW(STACK_AW)
  ) rrd_stack_mem_i (
    .clk(CLOCK),
    .rst_n(rst_n),
    .wr_en(push_take),
    .wr_addr(sp_r + 1'b1),
    .wr_data(PUSH_DATA),
    .rd_addr(sp_r),
    .rd_data(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // trap number check, aux decode, busy and observation read
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      trap_taken_r <= 1'b0;
      trap_reject_r <= 1'b0;
      trap_vec_r <= '0;
      aux_en_r <= '0;
      busy_r <= 1'b0;
      rd_data_r <= EXT_RESET;
    end else begin
      trap_taken_r <= op_take && (OP_CODE == OP_TRAP) && (TRAP_NUM <= TRAP_MAX);
      trap_reject_r <= op_take && (OP_CODE == OP_TRAP) && (TRAP_NUM > TRAP_MAX);
      if (op_take && (OP_CODE == OP_TRAP)) begin
        trap_vec_r <= TRAP_NUM;
      end
      aux_en_r <= AUX_STROBE ? rrd_onehot(AUX_FIELD) : '0;
      busy_r <= ret_taken;
      rd_data_r <= ext_r[RD_SEL];
    end
  end

  assign RD_DATA = rd_data_r;
  assign BUSY = busy_r;
  assign DONE = done_r;
  assign PC_OUT = pc_r;
  assign SP_OUT = sp_r;
  assign CARRY_OUT = carry_r;
  assign AUX_ENABLE = aux_en_r;
  assign TRAP_TAKEN = trap_taken_r;
  assign TRAP_REJECT = trap_reject_r;
  assign TRAP_VECTOR = trap_vec_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_ret_load;
    @(posedge CLOCK) disable iff (!rst_n) ret_taken |-> ##2 (PC_OUT == $past(mem_rdata));
  endproperty
  a_ret_load: assert property (p_ret_load) else $error("return did not load stack top");
  property p_ret_skip;
    @(posedge CLOCK) disable iff (!rst_n)
      (op_take && OP_CODE == OP_RETS && COND_GIVEN && !COND_TRUE) |=> (PC_OUT == $past(PC_OUT) + PC_STEP) && DONE;
  endproperty
  a_ret_skip: assert property (p_ret_skip) else $error("false condition did not continue");
  property p_rol;
    @(posedge CLOCK) disable iff (!rst_n) (op_take && OP_CODE == OP_ROL)
      |=> ext_r[$past(DST_SEL)][WORD_W-1:0] == {$past(dst_low[WORD_W-2:0]), $past(dst_low[WORD_W-1])};
  endproperty
  a_rol: assert property (p_rol) else $error("left rotate result wrong");
  property p_rotate_left_via_carry;
    @(posedge CLOCK) disable iff (!rst_n) (op_take && OP_CODE == OP_ROTATE_LEFT_VIA_CARRY)
      |=> ext_r[$past(DST_SEL)][0] == $past(carry_r) && CARRY_OUT == $past(dst_low[WORD_W-1]);
  endproperty
  a_rotate_left_via_carry: assert property (p_rotate_left_via_carry) else $error("left rotate through carry wrong");
  property p_ror;
    @(posedge CLOCK) disable iff (!rst_n) (op_take && OP_CODE == OP_ROR)
      |=> ext_r[$past(DST_SEL)][WORD_W-1:0] == {$past(dst_low[0]), $past(dst_low[WORD_W-1:1])};
  endproperty
  a_ror: assert property (p_ror) else $error("right rotate result wrong");
  property p_rotate_right_via_carry;
    @(posedge CLOCK) disable iff (!rst_n) (op_take && OP_CODE == OP_ROTATE_RIGHT_VIA_CARRY)
      |=> ext_r[$past(DST_SEL)][WORD_W-1] == $past(carry_r) && CARRY_OUT == $past(dst_low[0]);
  endproperty
  a_rotate_right_via_carry: assert property (p_rotate_right_via_carry) else $error("right rotate through carry wrong");

  property p_aux;
    @(posedge CLOCK) disable iff (!rst_n) AUX_STROBE |=> $onehot(AUX_ENABLE) && AUX_ENABLE[$past(AUX_FIELD)];
  endproperty
  a_aux: assert property (p_aux) else $error("aux select not one of eight");

  property p_load;
    @(posedge CLOCK) disable iff (!rst_n) load_take |=> ext_r[$past(LOAD_SEL)] == $past(LOAD_DATA);
  endproperty
  a_load: assert property (p_load) else $error("selected register not written");

  property p_trap;
    @(posedge CLOCK) disable iff (!rst_n) (op_take && OP_CODE == OP_TRAP && TRAP_NUM > TRAP_MAX)
      |=> TRAP_REJECT && !TRAP_TAKEN;
  endproperty
  a_trap: assert property (p_trap) else $error("out of range trap accepted");

  property p_rnd;
    @(posedge CLOCK) disable iff (!rst_n) (op_take && OP_CODE == OP_RND) |=> ext_r[$past(DST_SEL)] == $past(round_res)
      && (ext_r[$past(DST_SEL)][WORD_W-1:0] & ~ROUND_KEEP_MASK) == '0;
  endproperty
  a_rnd: assert property (p_rnd) else $error("round result wrong");

  property p_sp_dec;
    @(posedge CLOCK) disable iff (!rst_n) ret_taken |-> ##2 (SP_OUT == $past(SP_OUT, 2) - 1'b1);
  endproperty
  a_sp_dec: assert property (p_sp_dec) else $error("pointer not decremented after return");

endmodule : rrd_datapath
`default_nettype wire

// file: testbench/rrd_datapath_tb.sv
// self-checking testbench for the rotate/return datapath slice
`timescale 1ns/1ps
`default_nettype none
module rrd_datapath_tb
  import rrd_pkg::*;
;

  ////////////////////////////////////////////////////////////////////////////////
  // stimulus and observation signals
  logic clk, rst_n, op_valid, cond_given, cond_true, load_valid, push_valid, aux_strobe;
  rrd_op_t op_code;
  logic [SEL_W-1:0] dst_sel, load_sel, aux_field, rd_sel;
  logic [EXT_W-1:0] src_operand, load_data, rd_data;
  logic [TRAP_W-1:0] trap_num, trap_vector;
  logic [WORD_W-1:0] push_data, pc_out;
  logic [7:0] sp_out, aux_enable;
  logic busy, done, carry_out, trap_taken, trap_reject;
  int errors = 0;
  int n_tests = 0;
  logic [WORD_W-1:0] pc_exp = 32'h0000_0000;

  rrd_datapath rrd_datapath_i (
    .CLOCK(clk), .RST_N(rst_n), .OP_VALID(op_valid), .OP_CODE(op_code),
    .COND_GIVEN(cond_given), .COND_TRUE(cond_true), .DST_SEL(dst_sel),
    .SRC_OPERAND(src_operand), .TRAP_NUM(trap_num), .LOAD_VALID(load_valid),
    .LOAD_SEL(load_sel), .LOAD_DATA(load_data), .PUSH_VALID(push_valid),
    .PUSH_DATA(push_data), .AUX_STROBE(aux_strobe), .AUX_FIELD(aux_field),
    .RD_SEL(rd_sel), .RD_DATA(rd_data), .BUSY(busy), .DONE(done), .PC_OUT(pc_out),
    .SP_OUT(sp_out), .CARRY_OUT(carry_out), .AUX_ENABLE(aux_enable),
    .TRAP_TAKEN(trap_taken), .TRAP_REJECT(trap_reject), .TRAP_VECTOR(trap_vector)
  );

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic print_verdict();
    if (errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [EXT_W-1:0] seen, input logic [EXT_W-1:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one decoder request, released at the falling edge after the taking edge
  task automatic go(input rrd_op_t c, input logic cg, input logic ct, input logic [2:0] d);
    @(negedge clk);
    op_code = c;
    cond_given = cg;
    cond_true = ct;
    dst_sel = d;
    rd_sel = d;
    op_valid = 1'b1;
    @(posedge clk);
    @(negedge clk);
    op_valid = 1'b0;
  endtask : go

  task automatic load(input logic [2:0] d, input logic [EXT_W-1:0] v);
    @(negedge clk);
    load_valid = 1'b1;
    load_sel = d;
    load_data = v;
    @(negedge clk);
    load_valid = 1'b0;
  endtask : load

  task automatic push(input logic [WORD_W-1:0] v, input logic [7:0] sp_exp);
    @(negedge clk);
    push_valid = 1'b1;
    push_data = v;
    @(negedge clk);
    push_valid = 1'b0;
    chk("sp push", 40'(sp_out), 40'(sp_exp));
  endtask : push

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  // rotate: only the low word is judged, the carry flag travels between calls
  task automatic rot(input rrd_op_t c, input logic [2:0] d, input logic [31:0] din, input logic [31:0] dout,
                     input logic cexp);
    load(d, {8'h00, din});
    go(c, 1'b0, 1'b0, d);
    chk("done", 40'(done), 40'h1);
    pc_exp = pc_exp + PC_STEP;
    chk("pc", 40'(pc_out), 40'(pc_exp));
    @(negedge clk);
    chk("rot data", 40'(rd_data[31:0]), 40'(dout));
    chk("carry", 40'(carry_out), 40'(cexp));
  endtask : rot

  task automatic rnd(input logic [2:0] d, input logic [EXT_W-1:0] src, input logic [EXT_W-1:0] res);
    src_operand = src;
    go(OP_RND, 1'b0, 1'b0, d);
    pc_exp = pc_exp + PC_STEP;
    chk("round pc", 40'(pc_out), 40'(pc_exp));
    @(negedge clk);
    chk("round", rd_data, res);
  endtask : rnd

  // return; a taken one holds busy for one cycle and answers a cycle later
  task automatic ret(input logic cg, input logic ct, input logic [31:0] pc_new, input logic [7:0] sp_new);
    int k;
    go(OP_RETS, cg, ct, 3'h0);
    if (!cg || ct) begin
      chk("busy", 40'(busy), 40'h1);
      k = 0;
      while (done !== 1'b1 && k < 4) begin
        @(negedge clk);
        k++;
      end
      if (k >= 4) begin
        errors++;
        print_verdict();
      end
      chk("ret wait", 40'(k), 40'h1);
      pc_exp = pc_new;
    end else begin
      pc_exp = pc_exp + PC_STEP;
    end
    chk("ret pc", 40'(pc_out), 40'(pc_exp));
    chk("ret sp", 40'(sp_out), 40'(sp_new));
  endtask : ret

  task automatic aux_all();
    for (int k = 0; k < 8; k++) begin
      @(negedge clk);
      aux_strobe = 1'b1;
      aux_field = 3'(k);
      @(negedge clk);
      aux_strobe = 1'b0;
      chk("aux", 40'(aux_enable), 40'(8'h01 << k));
    end
    @(negedge clk);
    chk("aux idle", 40'(aux_enable), 40'h0);
  endtask : aux_all

  // trap range checks; every trap, refused or not, still advances the counter by one step
  task automatic traps();
    logic [4:0] nums [4] = '{5'h00, 5'h1B, 5'h1C, 5'h1F};
    for (int k = 0; k < 4; k++) begin
      trap_num = nums[k];
      go(OP_TRAP, 1'b0, 1'b0, 3'h0);
      pc_exp = pc_exp + PC_STEP;
      chk("trap pc", 40'(pc_out), 40'(pc_exp));
      chk("trap ok", 40'(trap_taken), 40'(nums[k] <= 5'h1B));
      chk("trap rej", 40'(trap_reject), 40'(nums[k] > 5'h1B));
      if (nums[k] <= 5'h1B) chk("trap vec", 40'(trap_vector), 40'(nums[k]));
    end
  endtask : traps

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {rst_n, op_valid, cond_given, cond_true, load_valid, push_valid, aux_strobe} = '0;
    op_code = OP_ROL;
    {dst_sel, load_sel, aux_field, rd_sel} = '0;
    {src_operand, load_data} = '0;
    trap_num = '0;
    push_data = '0;
    repeat (10) @(negedge clk);
    chk("pc reset", 40'(pc_out), 40'h0);
    chk("sp reset", 40'(sp_out), 40'h0);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    rot(OP_ROL, 3'h0, 32'h8000_0001, 32'h0000_0003, 1'b0);
    rot(OP_ROTATE_LEFT_VIA_CARRY, 3'h1, 32'h8000_0001, 32'h0000_0002, 1'b1);
    rot(OP_ROR, 3'h2, 32'h0000_0003, 32'h8000_0001, 1'b1);
    rot(OP_ROTATE_RIGHT_VIA_CARRY, 3'h3, 32'h0000_0002, 32'h8000_0001, 1'b0);
    rot(OP_ROTATE_RIGHT_VIA_CARRY, 3'h4, 32'h0000_0001, 32'h0000_0000, 1'b1);
    rot(OP_ROTATE_LEFT_VIA_CARRY, 3'h7, 32'h0000_0000, 32'h0000_0001, 1'b0);
    rnd(3'h5, 40'h05_1234_5680, 40'h05_1234_5700);
    rnd(3'h6, 40'h05_7FFF_FF80, 40'h06_4000_0000);
    push(32'h0000_0100, 8'h01);
    push(32'h0000_0200, 8'h02);
    ret(1'b1, 1'b0, 32'h0, 8'h02);
    ret(1'b1, 1'b1, 32'h0000_0200, 8'h01);
    ret(1'b0, 1'b0, 32'h0000_0100, 8'h00);
    aux_all();
    traps();
    print_verdict();
  end

endmodule : rrd_datapath_tb
`default_nettype wire
